// *** hw/frame_data_manager.sv ***
/*
 * frame_data_manager: manchester decoder, identifier/header matcher, serial
 * streamer and on/off sequencer of the receive path, with an APB register port.
 * assumes: demodulated data and the wake/config pins are asynchronous to pclk;
 * the APB master holds each request until pready.
 */
// The placing of the registers and register access over APB are this design's own decisions.
//
// Functional notes
// - stream as master, data valid on falling clock
// - optional extra byte; pad last byte arbitrarily
// - match identifier or its complement, length selectable
// - match header or complement; complement inverts data
// - half-bit from shortest pulse, tracked afterwards
// - equal consecutive levels end the message
// - first half carries data, second its inverse
// - off state powers down; low wake holds it
// - identifier search ends on match or on-time
// - header search times out after 256 bits
// - after header, stream data until end marker
// - low wake forces off; low config forces config
// - pad with filler to a multiple of eight
// - wake pin overrides internal oscillator command
// - manager disabled gives raw data, clock low
// - no header timeout without strobe oscillator
// - idle output drives clock and data low
`timescale 1ns/1ps

module frame_data_manager
    import frame_pkg::*;
#(
    parameter int ON_UNIT = 512,   // cycles per on-time step
    parameter int OFF_UNIT = 512   // cycles per off-time step
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire apb_req_s apb_req,
    output apb_rsp_s apb_rsp,
    input wire logic rx_data_in,
    input wire logic wake_force_on,
    input wire logic wake_hold_n,
    input wire logic config_select_n,
    output link_out_s link_out
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // mask of the low len bits
    function automatic logic [31:0] len_mask(input logic [5:0] len);
        logic [32:0] m;
        m = (33'h1 << len) - 33'h1;
        return m[31:0];
    endfunction

    // {exact, complement} match of the masked history
    function automatic logic [1:0] match(input logic [31:0] h, input logic [31:0] p,
                                         input logic [31:0] m);
        return {((h ^ p) & m) == 32'h0, ((~h ^ p) & m) == 32'h0};
    endfunction

    // mean of two periods
    function automatic logic [11:0] avg(input logic [11:0] a, input logic [11:0] b);
        logic [12:0] t;
        t = {1'b0, a} + {1'b0, b};
        return t[12:1];
    endfunction

    state_s s_ff;    // registered state
    state_s nxt_s;   // next state

    // ------------------------------------------------------------------
    // derived values
    // ------------------------------------------------------------------
    logic [13:0] on_cycles;    // programmed on time
    logic [13:0] off_cycles;   // programmed off time
    logic [13:0] short_thr;    // 1.5 half bits
    logic [13:0] long_thr;     // 2.5 half bits
    logic [5:0] id_len;        // identifier length in bits
    logic [5:0] hdr_len;       // header length in bits
    logic edge_seen;           // level changed this cycle
    logic bit_ev;              // a decoded bit is ready
    logic bit_val;             // its value
    logic eom_ev;              // code violation seen
    logic [31:0] hist_new;     // history including this bit
    logic [1:0] id_hit;        // {exact, complement}
    logic [1:0] hdr_hit;       // {exact, complement}
    logic apb_acc;             // first access cycle
    logic apb_wr;              // completing write

    assign on_cycles = 14'(s_ff.ctrl.on_time_field * ON_UNIT);
    assign off_cycles = 14'(s_ff.ctrl.off_time_field * OFF_UNIT);
    assign short_thr = {2'b00, s_ff.hb} + {3'b000, s_ff.hb[11:1]};
    assign long_thr = {1'b0, s_ff.hb, 1'b0} + {3'b000, s_ff.hb[11:1]};
    assign id_len = 6'((s_ff.ctrl.identifier_length_field + 3'h1) * ID_UNIT);
    assign hdr_len = 6'((s_ff.ctrl.header_length_field + 3'h1) * HDR_UNIT);
    assign edge_seen = s_ff.rx2 != s_ff.prev;
    assign hist_new = {s_ff.hist[30:0], bit_val};
    assign id_hit = (bit_ev && (s_ff.bitcnt + 9'h1) >= {3'b000, id_len})
                    ? match(hist_new, s_ff.id, len_mask(id_len)) : 2'b00;
    assign hdr_hit = (bit_ev && (s_ff.bitcnt + 9'h1) >= {3'b000, hdr_len})
                    ? match(hist_new, {16'h0000, s_ff.hdr}, len_mask(hdr_len)) : 2'b00;
    assign apb_acc = apb_req.psel && apb_req.penable && !s_ff.rsp.pready;
    assign apb_wr = apb_req.psel && apb_req.penable && s_ff.rsp.pready && apb_req.pwrite;

    // ------------------------------------------------------------------
    // manchester symbol decode
    // ------------------------------------------------------------------
    // a run of one half bit toggles the phase, a run of two lands mid-bit;
    // the bit value is the level before a mid-bit transition
    always_comb begin
        bit_ev = 1'b0;
        bit_val = s_ff.prev;
        eom_ev = 1'b0;
        if (edge_seen) begin
            if ({2'b00, s_ff.run} <= short_thr) begin
                bit_ev = !s_ff.at_mid;
            end else if ({2'b00, s_ff.run} <= long_thr) begin
                bit_ev = 1'b1;
            end else begin
                eom_ev = 1'b1;
            end
        end else if ({2'b00, s_ff.run} == long_thr + 14'h1) begin
            eom_ev = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        // synchronisers
        nxt_s.rx1 = rx_data_in;
        nxt_s.rx2 = s_ff.rx1;
        nxt_s.cf1 = config_select_n;
        nxt_s.cf2 = s_ff.cf1;
        nxt_s.on1 = wake_force_on;
        nxt_s.on2 = s_ff.on1;
        nxt_s.ho1 = wake_hold_n;
        nxt_s.ho2 = s_ff.ho1;
        // run length and clock recovery
        nxt_s.prev = s_ff.rx2;
        if (edge_seen) begin
            nxt_s.run = 12'h001;
            if (s_ff.st == ST_ID) begin
                // shortest pulse seen so far
                nxt_s.hb = (s_ff.run < s_ff.hb) ? s_ff.run : s_ff.hb;
            end else if ({2'b00, s_ff.run} <= short_thr) begin
                nxt_s.hb = avg(s_ff.hb, s_ff.run);
            end else if ({2'b00, s_ff.run} <= long_thr) begin
                nxt_s.hb = avg(s_ff.hb, {1'b0, s_ff.run[11:1]});
            end
            if ({2'b00, s_ff.run} <= short_thr) begin
                nxt_s.at_mid = !s_ff.at_mid;
            end else begin
                nxt_s.at_mid = ({2'b00, s_ff.run} <= long_thr);
            end
        end else if (s_ff.run != RUN_MAX) begin
            nxt_s.run = s_ff.run + 12'h001;
        end
        if (bit_ev) begin
            nxt_s.hist = hist_new;
            nxt_s.bitcnt = (s_ff.bitcnt == 9'h1FF) ? s_ff.bitcnt : s_ff.bitcnt + 9'h1;
        end
        // serial clock falls one half bit after it rose, data held meanwhile
        if (s_ff.gap != 13'h1FFF) begin
            nxt_s.gap = s_ff.gap + 13'h0001;
        end
        if (s_ff.lo.sclk && s_ff.gap >= {1'b0, s_ff.hb}) begin
            nxt_s.lo.sclk = 1'b0;
        end
        if (s_ff.tmr != TMR_MAX) begin
            nxt_s.tmr = s_ff.tmr + 14'h0001;
        end

        // on/off and frame sequencing
        if (!s_ff.cf2) begin
            nxt_s.st = ST_CFG;
        end else if (!s_ff.ho2) begin
            nxt_s.st = ST_OFF;
            nxt_s.tmr = 14'h0000;
        end else begin
            unique case (s_ff.st)
                ST_CFG: begin
                    nxt_s.st = ST_OFF;
                    nxt_s.tmr = 14'h0000;
                end
                ST_OFF: begin
                    // off timer ends the off phase only under the internal oscillator
                    if (s_ff.on2 || (s_ff.ctrl.strobe_osc_enable && s_ff.tmr >= off_cycles)) begin
                        nxt_s.st = ST_ID;
                    end
                end
                ST_ID: begin
                    if (s_ff.ctrl.data_manager_enable && id_hit != 2'b00) begin
                        nxt_s.st = ST_HDR;
                        nxt_s.bitcnt = 9'h000;
                    end else if (!s_ff.on2 && (!s_ff.ctrl.strobe_osc_enable
                                 || s_ff.tmr >= on_cycles)) begin
                        nxt_s.st = ST_OFF;
                        nxt_s.tmr = 14'h0000;
                    end
                end
                ST_HDR: begin
                    if (hdr_hit != 2'b00) begin
                        nxt_s.st = ST_DATA;
                        nxt_s.inv = !hdr_hit[1];
                        nxt_s.bitpos = BYTE_WRAP;
                    end else if (s_ff.ctrl.strobe_osc_enable && s_ff.bitcnt >= HDR_TIMEOUT) begin
                        nxt_s.st = ST_OFF;
                        nxt_s.tmr = 14'h0000;
                    end else if (!s_ff.ctrl.strobe_osc_enable && !s_ff.on2) begin
                        nxt_s.st = ST_OFF;
                        nxt_s.tmr = 14'h0000;
                    end
                end
                ST_DATA: begin
                    if (eom_ev) begin
                        nxt_s.st = (s_ff.bitpos != BYTE_WRAP) ? ST_FILL : ST_ID;
                        nxt_s.gap = 13'h0000;
                    end else if (bit_ev) begin
                        nxt_s.lo.mosi = bit_val ^ s_ff.inv;
                        nxt_s.lo.sclk = 1'b1;
                        nxt_s.gap = 13'h0000;
                        nxt_s.bitpos = s_ff.bitpos + 3'h1;
                    end
                end
                ST_FILL: begin
                    // one filler bit per recovered bit period
                    if (!s_ff.lo.sclk && s_ff.gap >= {s_ff.hb, 1'b0}) begin
                        if (s_ff.bitpos == BYTE_WRAP) begin
                            nxt_s.st = ST_ID;
                        end else begin
                            nxt_s.lo.mosi = 1'b0;
                            nxt_s.lo.sclk = 1'b1;
                            nxt_s.gap = 13'h0000;
                            nxt_s.bitpos = s_ff.bitpos + 3'h1;
                        end
                    end
                end
                default: begin
                    nxt_s.st = ST_OFF;
                end
            endcase
        end

        // fresh search: no partial match survives
        if (nxt_s.st == ST_ID && s_ff.st != ST_ID) begin
            nxt_s.hist = 32'h0;
            nxt_s.bitcnt = 9'h000;
            nxt_s.hb = HB_MAX;
            nxt_s.at_mid = 1'b0;
            nxt_s.inv = 1'b0;
            nxt_s.tmr = 14'h0000;
        end

        // pins outside streaming
        nxt_s.lo.rx_power_on = !(nxt_s.st == ST_OFF || nxt_s.st == ST_CFG);
        nxt_s.lo.config_mode = nxt_s.st == ST_CFG;
        if (!s_ff.ctrl.data_manager_enable) begin
            nxt_s.lo.sclk = 1'b0;
            nxt_s.lo.mosi = nxt_s.lo.rx_power_on && s_ff.rx2;
        end else if (!(nxt_s.st == ST_DATA || nxt_s.st == ST_FILL)) begin
            nxt_s.lo.sclk = 1'b0;
            nxt_s.lo.mosi = 1'b0;
        end

        // apb slave: one wait state, data and error registered
        nxt_s.rsp.pready = apb_acc;
        if (apb_acc) begin
            nxt_s.rsp.pslverr = 1'b0;
            unique case (apb_req.paddr)
                OFS_CTRL: nxt_s.rsp.prdata = {16'h0000, s_ff.ctrl};
                OFS_ID: nxt_s.rsp.prdata = s_ff.id;
                OFS_HDR: nxt_s.rsp.prdata = {16'h0000, s_ff.hdr};
                OFS_STATUS: nxt_s.rsp.prdata = {9'h000, s_ff.st, s_ff.inv, s_ff.bitpos,
                                                 4'h0, s_ff.hb};
                default: begin
                    nxt_s.rsp.prdata = 32'h0;
                    nxt_s.rsp.pslverr = 1'b1;
                end
            endcase
        end
        if (apb_wr) begin
            unique case (apb_req.paddr)
                OFS_CTRL: begin
                    nxt_s.ctrl = ctrl_s'(apb_req.pwdata[15:0]);
                    nxt_s.ctrl.rsvd = 2'b00;
                end
                OFS_ID: nxt_s.id = apb_req.pwdata;
                OFS_HDR: nxt_s.hdr = apb_req.pwdata[15:0];
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= '0;
            s_ff.ctrl <= ctrl_s'(CTRL_RST);
            s_ff.id <= ID_RST;
            s_ff.hdr <= HDR_RST;
        end else if (clk_en) begin
            s_ff <= nxt_s;
        end
    end

    assign apb_rsp = s_ff.rsp;
    assign link_out = s_ff.lo;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence eom_in_data;
        clk_en && s_ff.cf2 && s_ff.ho2 && s_ff.st == ST_DATA && eom_ev;
    endsequence
    sequence leave_stream;
        ##1 (s_ff.st == ST_FILL || s_ff.st == ST_ID);
    endsequence
    sequence hdr_comp_seen;
        clk_en && s_ff.cf2 && s_ff.ho2 && s_ff.st == ST_HDR && hdr_hit == 2'b01;
    endsequence

    cfg_force_a: assert property (clk_en && !s_ff.cf2 |=> s_ff.st == ST_CFG)
        else $error("config select low did not force config mode");
    wake_off_a: assert property (clk_en && s_ff.cf2 && !s_ff.ho2 |=> s_ff.st == ST_OFF
                                 ##0 !s_ff.lo.rx_power_on)
        else $error("wake low did not hold receiver off");
    raw_mode_a: assert property (clk_en && !s_ff.ctrl.data_manager_enable |=> !s_ff.lo.sclk)
        else $error("clock active with manager disabled");
    idle_low_a: assert property (s_ff.ctrl.data_manager_enable && s_ff.st == ST_OFF
                                 |-> !s_ff.lo.sclk && !s_ff.lo.mosi)
        else $error("clock or data high while idle");
    id_hit_a: assert property (clk_en && s_ff.cf2 && s_ff.ho2 && s_ff.st == ST_ID
                               && s_ff.ctrl.data_manager_enable && id_hit != 2'b00
                               |=> s_ff.st == ST_HDR && s_ff.bitcnt == 9'h000)
        else $error("identifier match did not start header search");
    hdr_tout_a: assert property (clk_en && s_ff.cf2 && s_ff.ho2 && s_ff.st == ST_HDR
                                 && hdr_hit == 2'b00 && s_ff.ctrl.strobe_osc_enable
                                 && s_ff.bitcnt == HDR_TIMEOUT |=> s_ff.st == ST_OFF)
        else $error("header search outlived its timeout");
    no_tout_a: assert property (s_ff.st == ST_HDR && !s_ff.ctrl.strobe_osc_enable
                                && s_ff.on2 && s_ff.ho2 && s_ff.cf2 && hdr_hit == 2'b00
                                |=> s_ff.st == ST_HDR)
        else $error("header search ended while wake held high");
    inv_set_a: assert property (hdr_comp_seen |=> s_ff.st == ST_DATA && s_ff.inv)
        else $error("complemented header did not invert data");
    eom_end_a: assert property (eom_in_data |-> leave_stream)
        else $error("violation did not end streaming");
    fill_byte_a: assert property (s_ff.st == ST_FILL ##1 s_ff.st == ST_ID
                                  |-> s_ff.bitpos == BYTE_WRAP)
        else $error("stream ended off a byte boundary");
    data_hold_a: assert property (s_ff.lo.sclk && $past(s_ff.lo.sclk)
                                  |-> $stable(s_ff.lo.mosi))
        else $error("data changed while clock high");
    search_clr_a: assert property ($rose(s_ff.st == ST_ID)
                                   |-> s_ff.hist == 32'h0 && s_ff.bitcnt == 9'h000)
        else $error("search entered with stale match state");

endmodule

// *** hw/frame_pkg.sv ***
/*
 * frame_pkg: constants, register layout, state enumeration and carrier structs
 * for the manchester frame data manager.
 * assumes: a 32-bit APB register bus and a single pclk domain.
 */
package frame_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL = 12'h000;   // mode and length fields
    localparam logic [11:0] OFS_ID = 12'h004;     // stored identifier
    localparam logic [11:0] OFS_HDR = 12'h008;    // stored header
    localparam logic [11:0] OFS_STATUS = 12'h00C; // live state, read only

    localparam logic [15:0] CTRL_RST = 16'h0000;  // manager and oscillator off
    localparam logic [31:0] ID_RST = 32'h00000000;
    localparam logic [15:0] HDR_RST = 16'h0000;

    // ------------------------------------------------------------------
    // framing constants
    // ------------------------------------------------------------------
    localparam logic [5:0] ID_UNIT = 6'h08;       // identifier bits per length step
    localparam logic [5:0] HDR_UNIT = 6'h04;      // header bits per length step
    localparam logic [8:0] HDR_TIMEOUT = 9'h100;  // header search limit in bits
    localparam logic [2:0] BYTE_WRAP = 3'h0;      // bit position at a byte boundary
    localparam logic [11:0] HB_MAX = 12'hFFF;     // half-bit estimate before any pulse
    localparam logic [11:0] RUN_MAX = 12'hFFF;    // run counter saturation
    localparam logic [13:0] TMR_MAX = 14'h3FFF;   // on/off timer saturation

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {ST_OFF, ST_ID, ST_HDR, ST_DATA, ST_FILL, ST_CFG} mstate_e;

    typedef struct packed {
        logic [3:0] off_time_field;          // off time in units of OFF_UNIT cycles
        logic [3:0] on_time_field;           // on time in units of ON_UNIT cycles
        logic [1:0] rsvd;                    // reads as zero
        logic [1:0] header_length_field;     // header length step
        logic [1:0] identifier_length_field; // identifier length step
        logic strobe_osc_enable;             // internal on/off cycling
        logic data_manager_enable;           // decode and stream, else raw data
    } ctrl_s;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_s;

    typedef struct packed {
        logic sclk;          // recovered serial clock out
        logic mosi;          // serial data out
        logic rx_power_on;   // receiver front end powered
        logic config_mode;   // configuration mode active
    } link_out_s;

    // whole state of the data manager
    typedef struct packed {
        mstate_e st;
        logic rx1, rx2;      // demodulated data synchroniser
        logic cf1, cf2;      // config select synchroniser
        logic on1, on2;      // wake forced high synchroniser
        logic ho1, ho2;      // wake forced low synchroniser
        ctrl_s ctrl;
        logic [31:0] id;
        logic [15:0] hdr;
        logic prev;          // level before current run
        logic [11:0] run;    // cycles since last transition
        logic [11:0] hb;     // half-bit period estimate
        logic at_mid;        // last transition was mid-bit
        logic [31:0] hist;   // decoded bit history
        logic [8:0] bitcnt;  // bits decoded in current search state
        logic [13:0] tmr;    // on/off timer
        logic [2:0] bitpos;  // bit position in current output byte
        logic inv;           // complemented header seen
        logic [12:0] gap;    // cycles since last output bit
        link_out_s lo;
        apb_rsp_s rsp;
    } state_s;

endpackage

// *** tb/manch_src.sv ***
/* manch_src: manchester transmitter on the demodulated data input.
   assumes: 320 ns bit period; the caller builds preamble, id, header, payload. */
`timescale 1ns/1ps
module manch_src (
    output logic rx
);
    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    initial rx = 1'b0; // idle low before the first frame
    // hold the line high so the front end gain can settle before a preamble
    task automatic settle();
        rx = 1'b1;
        #200000;
    endtask
    // send n bits msb first without gaps, then hold the line as end marker
    task automatic send(input logic [63:0] b, input int n);
        #7; // keep line changes away from the sampling clock edges
        for (int i = n - 1; i >= 0; i--) begin
            rx = b[i]; // data half
            #160; // equal halves
            rx = ~b[i]; // inverse half
            #160;
        end
        #640; // equal levels close the frame
    endtask
endmodule

// *** tb/tb_top.sv ***
/* tb_top: self-checking bench for frame_data_manager.
   assumes: 25 MHz pclk, manch_src on rx, bytes taken on falling sclk. */
`timescale 1ns/1ps
module tb_top;
    import frame_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic pclk, presetn;
    apb_req_s req; // bus request
    apb_rsp_s rsp; // bus answer
    link_out_s lo; // serial outputs
    wire logic rx;
    logic [7:0] q[$]; // expected bytes
    logic [7:0] sh = 8'h0; // received byte
    int nb = 0;
    int error_cnt = 0;
    int comparisons = 0;
    logic [31:0] rd;
    logic er;
    logic [7:0] p;
    int cnt; // cycles counted in one power phase
    localparam int UNIT = 4; // short timer step keeps the run brief
    logic wk_on = 1'b1; // wake pin forced high until the pin test: receiver held on, not strobed
    logic wk_n = 1'b1; // wake pin not pulled low
    logic cfg_n = 1'b1; // configuration select inactive
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    manch_src src (.rx(rx));
    frame_data_manager #(.ON_UNIT(UNIT), .OFF_UNIT(UNIT)) DUT (.pclk(pclk), .presetn(presetn),
        .clk_en(1'b1), .apb_req(req), .apb_rsp(rsp), .rx_data_in(rx), .wake_force_on(wk_on),
        .wake_hold_n(wk_n), .config_select_n(cfg_n), .link_out(lo));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        r = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
        if (n == 50) error_cnt++;
    endtask
    // note the byte, send the frame, then see it was consumed
    task automatic frame(input logic [63:0] b, input int n, input logic [7:0] e);
        q.push_back(e);
        src.settle();
        src.send(b, n);
        repeat (60) @(posedge pclk);
        check("bytes left", q.size(), 0);
        $display("frame test done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // monitor: assemble bytes on falling sclk, compare with oldest note
    // ------------------------------------------------------------
    // the fall from unknown to low as reset asserts is not a data edge
    always @(negedge lo.sclk) begin
        if (presetn === 1'b1) begin
            sh = {sh[6:0], lo.mosi};
            nb++;
            if (nb == 8) begin
                nb = 0;
                check("byte", {24'h0, sh}, q.size() > 0 ? {24'h0, q.pop_front()} : 32'hX);
            end
        end
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        req = '0;
        presetn = 1'b0;
        void'($urandom(32'h4C411389));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        apb(1'b0, OFS_CTRL, 32'h0, rd, er);
        check("ctrl reset", rd, {16'h0, CTRL_RST});
        apb(1'b1, OFS_CTRL, 32'h1, rd, er);
        apb(1'b1, OFS_ID, 32'hA5, rd, er);
        apb(1'b1, OFS_HDR, 32'hC, rd, er);
        apb(1'b0, 12'h010, 32'h0, rd, er);
        check("unmapped", {31'h0, er}, 32'h1);
        $display("register test done");
        p = 8'($urandom);
        frame({28'h0, 16'h3333, 8'hA5, 4'hC, p}, 36, p);
        frame({28'h0, 16'h3333, 8'h5A, 4'h3, p}, 36, ~p);
        frame({32'h0, 16'h3333, 8'hA5, 4'hC, p[7:4]}, 32, {p[7:4], 4'h0});
        // oscillator on: identifier, then more than 256 bits with no header
        apb(1'b1, OFS_CTRL, 32'h3, rd, er);
        src.send({16'h3333, 8'hA5, 40'hFF_FFFF_FFFF}, 64);
        repeat (5) src.send({64{1'b1}}, 64);
        apb(1'b0, OFS_STATUS, 32'h0, rd, er);
        check("hdr timeout", {29'h0, rd[22:20]}, 32'(ST_ID));
        $display("timeout test done");
        apb(1'b1, OFS_CTRL, 32'h0, rd, er);
        fork
            src.send(64'h1, 1);
            begin
                #150;
                check("raw out", {30'h0, lo.sclk, lo.mosi}, 32'h1);
                #150;
                check("raw out low", {30'h0, lo.sclk, lo.mosi}, 32'h0);
            end
        join
        $display("raw test done");
        // pins: config select, wake held low, then oscillator on/off cycling
        @(posedge pclk);
        cfg_n <= 1'b0;
        repeat (5) @(posedge pclk);
        #1 check("config", {30'h0, lo.config_mode, lo.rx_power_on}, 32'h2);
        @(posedge pclk);
        cfg_n <= 1'b1;
        wk_n <= 1'b0;
        repeat (5) @(posedge pclk);
        #1 check("wake low", {30'h0, lo.config_mode, lo.rx_power_on}, 32'h0);
        @(posedge pclk);
        wk_n <= 1'b1;
        wk_on <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h3202, rd, er);
        @(posedge lo.rx_power_on);
        cnt = 0;
        do begin
            @(posedge pclk);
            #1 cnt++;
        end while (lo.rx_power_on === 1'b1);
        check("on time", {31'h0, cnt >= 2 * UNIT && cnt <= 2 * UNIT + 1}, 32'h1);
        cnt = 0;
        do begin
            @(posedge pclk);
            #1 cnt++;
        end while (lo.rx_power_on === 1'b0);
        check("off time", {31'h0, cnt >= 3 * UNIT && cnt <= 3 * UNIT + 1}, 32'h1);
        $display("pin test done");
        report_and_stop();
    end
    initial begin
        #1200000;
        error_cnt++;
        report_and_stop();
    end
endmodule
